// File: tb.sv
`timescale 1ns/1ns
`include "vsx_cfg.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb;
    import vsx_pkg::*;
    logic sys_clk, rstn, issue_valid, issue_ready, older_done, prefetch_flush, refetch_valid;
    logic wb_valid, is_spr_read, cache_valid, cache_skip_check, cache_broadcast, cache_wb_invalid;
    logic segment_direct_store_flag, page_not_global, phys_addr_invalid, bus_req, bus_write;
    logic bus_doe, bus_ack, reg_wr, reg_rd, irq, slow, s_wb, s_cv, s_sk, s_bc, s_pf, s_rf, s_req;
    logic early;
    logic [31:0] instr, eff_addr, phys_addr, src_data, time_base_val, refetch_addr, next_addr_in;
    logic [31:0] wb_data, cache_addr, bus_addr, bus_dout, bus_din, reg_wdata, reg_rdata;
    logic [31:0] rd_word, last_addr, last_wdata, s_wd, s_ra;
    logic [3:0] cache_op, bus_tbst, reg_addr, s_op;
    int fails = 0, checks_done = 0;
    logic [9:0] tbx[2] = '{`VSX_XO_MFTB, `VSX_XO_MFSPR};
    logic [9:0] cbx[6] = '{`VSX_XO_DCBF, `VSX_XO_DCBZ, `VSX_XO_DCBST, `VSX_XO_DCBT,
        `VSX_XO_DCBTST, `VSX_XO_ICBI};
    vsx_exec i_vsx_exec (.sys_clk, .rstn, .issue_valid, .issue_ready, .instr, .eff_addr, .phys_addr,
        .src_data, .segment_direct_store_flag, .page_not_global, .phys_addr_invalid, .time_base_val,
        .older_done, .prefetch_flush, .refetch_valid, .refetch_addr, .next_addr_in, .wb_valid,
        .wb_data, .is_spr_read, .cache_valid, .cache_op, .cache_addr, .cache_skip_check,
        .cache_broadcast, .cache_wb_invalid, .bus_req, .bus_write, .bus_addr, .bus_tbst, .bus_dout,
        .bus_doe, .bus_din, .bus_ack, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
    vsx_ecdev i_vsx_ecdev (.sys_clk, .rstn, .bus_req, .bus_write, .bus_addr, .bus_tbst, .bus_dout,
        .bus_din, .bus_ack, .rd_word, .last_addr, .last_wdata, .slow);
    function automatic logic [31:0] ins(input logic [9:0] x);
        return {(x == `VSX_XO_ISYNC) ? `VSX_PO_X19 : `VSX_PO_EXT, 15'h0000, x, 1'b0};
    endfunction
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask
    task automatic iss(input logic [9:0] x);
        int n;
        @(posedge sys_clk);
        {issue_valid, instr} <= {1'b1, ins(x)};
        @(negedge sys_clk);
        for (n = 0; n < 40 && issue_ready !== 1'b1; n++) @(negedge sys_clk);
        {s_wb, s_wd, s_cv, s_op} = {wb_valid, wb_data, cache_valid, cache_op};
        {s_sk, s_bc, s_pf, s_rf, s_req, early} = {cache_skip_check, cache_broadcast, prefetch_flush, 3'b000};
        @(posedge sys_clk);
        issue_valid <= 1'b0;
        for (n = 0; n < 60; n++) begin
            @(negedge sys_clk);
            if (wb_valid) s_wd = wb_data;
            if (refetch_valid) s_ra = refetch_addr;
            early |= refetch_valid & ~older_done;
            s_rf |= refetch_valid;
            s_req |= bus_req;
            if (issue_ready && n > 0) break;
        end
    endtask
    task automatic stop_test();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        #200000 fails++;
        stop_test();
    end
    initial begin
        {rstn, issue_valid, reg_wr, reg_rd, segment_direct_store_flag, page_not_global} = '0;
        {phys_addr_invalid, cache_wb_invalid, slow, instr, reg_addr, reg_wdata} = '0;
        {older_done, eff_addr, phys_addr} = {1'b1, 32'h0000_1000, 32'h0008_1000};
        {src_data, time_base_val, rd_word} = {32'h5a5a_c3c3, 32'h1234_5678, 32'hcafe_0042};
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        #1 `CHK(issue_ready, 1'b0)
        wr(`VSX_REG_CTRL, 32'h0000_0002);
        wr(`VSX_REG_EAR, 32'h0000_0009);
        rd(`VSX_REG_EAR, 32'h0000_0009);
        rd(4'hf, 32'h0000_0000);
        foreach (tbx[i]) begin
            iss(tbx[i]);
            `CHK({s_wb, s_wd}, {1'b1, time_base_val})
        end
        iss(`VSX_XO_EIEIO);
        `CHK({s_wb, s_cv, s_req}, 3'b000)
        page_not_global <= 1'b1;
        iss(`VSX_XO_DCBZ);
        `CHK({s_cv, s_sk, s_bc, s_op}, {3'b110, 4'(VSX_OP_DCBZ)})
        {page_not_global, segment_direct_store_flag} <= 2'b01;
        foreach (cbx[i]) begin
            iss(cbx[i]);
            `CHK(s_cv, 1'b0)
        end
        $display("test cache done");
        segment_direct_store_flag <= 1'b0;
        older_done <= 1'b0;
        fork
            begin
                repeat (8) @(posedge sys_clk);
                older_done <= 1'b1;
            end
        join_none
        iss(`VSX_XO_ISYNC);
        `CHK({s_pf, s_rf, early, s_ra}, {3'b110, eff_addr + 32'h0000_0004})
        wr(`VSX_REG_STAT, 32'h0000_001f);
        cache_wb_invalid <= 1'b1;
        repeat (3) @(posedge sys_clk);
        cache_wb_invalid <= 1'b0;
        rd(`VSX_REG_STAT, 32'h0000_0004);
        `CHK(irq, 1'b0)
        wr(`VSX_REG_MASK, 32'h0000_001f);
        `CHK(irq, 1'b1)
        wr(`VSX_REG_STAT, 32'h0000_0004);
        `CHK(irq, 1'b0)
        $display("test sync done");
        wr(`VSX_REG_CTRL, 32'h0000_0003);
        slow <= 1'b1;
        iss(`VSX_XO_ECIWX);
        `CHK({s_wd, last_addr}, {rd_word, phys_addr})
        rd(`VSX_REG_RDATA, rd_word);
        slow <= 1'b0;
        iss(`VSX_XO_ECOWX);
        `CHK(last_wdata, src_data)
        wr(`VSX_REG_STAT, 32'h0000_001f);
        segment_direct_store_flag <= 1'b1;
        iss(`VSX_XO_ECIWX);
        `CHK(s_req, 1'b0)
        rd(`VSX_REG_STAT, 32'h0000_0001);
        `CHK(irq, 1'b1)
        wr(`VSX_REG_STAT, 32'h0000_001f);
        segment_direct_store_flag <= 1'b0;
        wr(`VSX_REG_CTRL, 32'h0000_0002);
        iss(`VSX_XO_ECOWX);
        rd(`VSX_REG_STAT, 32'h0000_000a);
        rd(`VSX_REG_COUNT, 32'h0000_0003);
        $display("test external done");
        stop_test();
    end
endmodule // tb

// File: vsx_cfg.svh
`ifndef VSX_CFG_SVH
`define VSX_CFG_SVH
// Primary opcode field and extended opcode field positions
`define VSX_PO_HI 31
`define VSX_PO_LO 26
`define VSX_XO_HI 10
`define VSX_XO_LO 1
`define VSX_XO_ALIAS_BIT 5
`define VSX_PO_EXT 6'h1f
`define VSX_PO_X19 6'h13
`define VSX_XO_MFSPR 10'h153
`define VSX_XO_MFTB 10'h173
`define VSX_XO_ISYNC 10'h096
`define VSX_XO_EIEIO 10'h356
`define VSX_XO_DCBF 10'h056
`define VSX_XO_DCBZ 10'h3f6
`define VSX_XO_DCBST 10'h036
`define VSX_XO_DCBT 10'h116
`define VSX_XO_DCBTST 10'h0f6
`define VSX_XO_ICBI 10'h3d6
`define VSX_XO_ECIWX 10'h136
`define VSX_XO_ECOWX 10'h1b6
// Register map
`define VSX_REG_CTRL 4'h0
`define VSX_REG_EAR 4'h1
`define VSX_REG_STAT 4'h2
`define VSX_REG_MASK 4'h3
`define VSX_REG_RDATA 4'h4
`define VSX_REG_COUNT 4'h5
// Control bit positions
`define VSX_CTRL_DTE 0
`define VSX_CTRL_EN 1
// Status event positions
`define VSX_EV_DSI 0
`define VSX_EV_PROG 1
`define VSX_EV_MCHK 2
`define VSX_EV_ECDONE 3
`define VSX_EV_ISYNC 4
`define VSX_NEV 5
`define VSX_RID_W 4
`define VSX_CTRL_RST 32'h0000_0000
`endif

// File: vsx_ecdev.sv
`timescale 1ns/1ns
module vsx_ecdev #(
    parameter logic [3:0] RESOURCE_IDENTIFIER = 4'h9
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic bus_req,
    input wire logic bus_write,
    input wire logic [31:0] bus_addr,
    input wire logic [3:0] bus_tbst,
    input wire logic [31:0] bus_dout,
    output logic [31:0] bus_din,
    output logic bus_ack,
    input wire logic [31:0] rd_word,
    output logic [31:0] last_addr,
    output logic [31:0] last_wdata,
    input wire logic slow
);
    logic [2:0] cnt_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            {cnt_q, bus_ack, last_addr, last_wdata} <= '0;
        end else if (bus_req && bus_tbst == RESOURCE_IDENTIFIER) begin
            cnt_q <= cnt_q + 3'd1;
            if (cnt_q >= (slow ? 3'd5 : 3'd0)) begin
                bus_ack <= 1'b1;
                last_addr <= bus_addr;
                if (bus_write) last_wdata <= bus_dout;
            end
        end else begin
            cnt_q <= '0;
            bus_ack <= 1'b0;
        end
    end
    // Released bus shows the inverse word
    assign bus_din = bus_ack ? rd_word : ~rd_word;
endmodule // vsx_ecdev

// File: vsx_exec.sv
// Overview of operation
// - Ignore bit 25; time-base read equals special read
// - Isync flushes prefetch, drains, refetches next address
// - I/O ordering barrier executes as no-op
// - Zero-block allocates unchecked when translation off
// - Invalid block write-back may raise machine check
// - Cache ops in direct-store segment are no-ops
// - Aliased write-through then zero-block may be incoherent
// - Zero-block not broadcast when memory not global
// - Translated address is operand on address bus
// - Resource identifier driven on burst/size lines
// - Input transfer loads device word to destination
// - Transfer with translation off is programming error
// - Direct-store transfer raises data storage exception
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
`include "vsx_cfg.svh"
module vsx_exec
    import vsx_pkg::*;
#(
    parameter int AW = 32,
    parameter int DW = 32
) (
    input wire logic sys_clk,
    input wire logic rstn,
    // Instruction issue
    input wire logic issue_valid,
    output logic issue_ready,
    input wire logic [31:0] instr,
    input wire logic [AW-1:0] eff_addr,
    input wire logic [AW-1:0] phys_addr,
    input wire logic [DW-1:0] src_data,
    input wire logic segment_direct_store_flag,
    input wire logic page_not_global,
    input wire logic phys_addr_invalid,
    input wire logic [DW-1:0] time_base_val,
    input wire logic older_done,
    output logic prefetch_flush,
    output logic refetch_valid,
    output logic [AW-1:0] refetch_addr,
    output logic [AW-1:0] next_addr_in,
    output logic wb_valid,
    output logic [DW-1:0] wb_data,
    output logic is_spr_read,
    // Cache controller
    output logic cache_valid,
    output logic [3:0] cache_op,
    output logic [AW-1:0] cache_addr,
    output logic cache_skip_check,
    output logic cache_broadcast,
    input wire logic cache_wb_invalid,
    // System bus
    output logic bus_req,
    output logic bus_write,
    output logic [AW-1:0] bus_addr,
    output logic [`VSX_RID_W-1:0] bus_tbst,
    output logic [DW-1:0] bus_dout,
    output logic bus_doe,
    input wire logic [DW-1:0] bus_din,
    input wire logic bus_ack,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq
);
    vsx_state_t st_q, st_d;
    vsx_op_t op;
    logic [5:0] po;
    logic [9:0] xo;
    logic [9:0] xo_m;
    logic [1:0] in_s;
    logic ack_s, mchk_s;
    logic [31:0] ctrl_q, ctrl_d;
    logic [`VSX_RID_W-1:0] ear_q, ear_d;
    logic [`VSX_NEV-1:0] stat_q, stat_d, mask_q, mask_d, ev;
    logic [DW-1:0] rd_q, rd_d;
    logic [31:0] cnt_q, cnt_d;
    logic [31:0] rdata_q, rdata_d;
    logic [AW-1:0] pc_q, pc_d, addr_q, addr_d;
    logic [DW-1:0] data_q, data_d;
    logic wr_q, wr_d, ack_q;
    logic dte, en, take;

    // Bus answers come from another agent's timing; synchronise them
    vsx_sync2 #(.W(2)) u_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .din({bus_ack, cache_wb_invalid}),
        .dout(in_s)
    );
    assign ack_s = in_s[1];
    assign mchk_s = in_s[0];

    assign dte = ctrl_q[`VSX_CTRL_DTE];
    assign en = ctrl_q[`VSX_CTRL_EN];
    assign po = instr[`VSX_PO_HI:`VSX_PO_LO];
    assign xo = instr[`VSX_XO_HI:`VSX_XO_LO];
    // Bit 25 in big-endian numbering is XO bit 5 here
    assign xo_m = xo & ~(10'h001 << `VSX_XO_ALIAS_BIT);

    always_comb begin
        op = VSX_OP_NONE;
        if (po == `VSX_PO_X19) begin
            if (xo == `VSX_XO_ISYNC) begin
                op = VSX_OP_ISYNC;
            end
        end else if (po == `VSX_PO_EXT) begin
            case (xo)
                `VSX_XO_EIEIO: op = VSX_OP_EIEIO;
                `VSX_XO_DCBF: op = VSX_OP_DCBF;
                `VSX_XO_DCBZ: op = VSX_OP_DCBZ;
                `VSX_XO_DCBST: op = VSX_OP_DCBST;
                `VSX_XO_DCBT: op = VSX_OP_DCBT;
                `VSX_XO_DCBTST: op = VSX_OP_DCBTST;
                `VSX_XO_ICBI: op = VSX_OP_ICBI;
                `VSX_XO_ECIWX: op = VSX_OP_ECIN;
                `VSX_XO_ECOWX: op = VSX_OP_ECOUT;
                default: begin
                    if (xo_m == `VSX_XO_MFSPR) begin
                        op = VSX_OP_TB;
                    end
                end
            endcase
        end
    end

    assign issue_ready = en && (st_q == VSX_IDLE);
    assign take = issue_valid && issue_ready;
    assign is_spr_read = (op == VSX_OP_TB);
    assign next_addr_in = eff_addr;

    // Cache control path
    always_comb begin
        cache_valid = 1'b0;
        cache_op = op;
        cache_addr = phys_addr;
        cache_skip_check = 1'b0;
        cache_broadcast = 1'b0;
        if (take && op >= VSX_OP_DCBF && op <= VSX_OP_ICBI) begin
            cache_valid = !segment_direct_store_flag;
            cache_skip_check = (op == VSX_OP_DCBZ) && !dte;
            // Aliased write-through plus zero-block left to software
            cache_op = op;
            // Broadcast only for global memory
            cache_broadcast = !page_not_global;
        end
    end

    always_comb begin
        st_d = st_q;
        pc_d = pc_q;
        addr_d = addr_q;
        data_d = data_q;
        wr_d = wr_q;
        rd_d = rd_q;
        ev = '0;
        prefetch_flush = 1'b0;
        refetch_valid = 1'b0;
        wb_valid = 1'b0;
        wb_data = '0;
        case (st_q)
            VSX_IDLE: begin
                if (take) begin
                    case (op)
                        VSX_OP_TB: begin
                            wb_valid = 1'b1;
                            wb_data = time_base_val;
                        end
                        VSX_OP_ISYNC: begin
                            prefetch_flush = 1'b1;
                            pc_d = eff_addr + AW'(4);
                            st_d = VSX_DRAIN;
                        end
                        VSX_OP_EIEIO: begin
                            st_d = VSX_IDLE;
                        end
                        VSX_OP_ECIN, VSX_OP_ECOUT: begin
                            if (segment_direct_store_flag) begin
                                ev[`VSX_EV_DSI] = 1'b1;
                            end else begin
                                // Address undefined when translation off
                                ev[`VSX_EV_PROG] = !dte;
                                addr_d = phys_addr;
                                data_d = src_data;
                                wr_d = (op == VSX_OP_ECOUT);
                                st_d = VSX_BUSREQ;
                            end
                        end
                        default: st_d = VSX_IDLE;
                    endcase
                end
            end
            VSX_DRAIN: begin
                if (older_done) begin
                    st_d = VSX_REFETCH;
                end
            end
            VSX_REFETCH: begin
                refetch_valid = 1'b1;
                ev[`VSX_EV_ISYNC] = 1'b1;
                st_d = VSX_IDLE;
            end
            VSX_BUSREQ: begin
                st_d = VSX_BUSWAIT;
            end
            VSX_BUSWAIT: begin
                if (ack_s) begin
                    rd_d = bus_din;
                    st_d = VSX_DONE;
                end
            end
            VSX_DONE: begin
                wb_valid = !wr_q;
                wb_data = rd_q;
                ev[`VSX_EV_ECDONE] = 1'b1;
                st_d = VSX_IDLE;
            end
            default: st_d = VSX_IDLE;
        endcase
        ev[`VSX_EV_MCHK] = mchk_s;
    end

    assign refetch_addr = pc_q;
    assign bus_req = (st_q == VSX_BUSREQ) || (st_q == VSX_BUSWAIT);
    assign bus_write = wr_q;
    assign bus_addr = addr_q;
    assign bus_tbst = ear_q;
    assign bus_dout = data_q;
    assign bus_doe = bus_req && wr_q;

    // Register port
    always_comb begin
        ctrl_d = ctrl_q;
        ear_d = ear_q;
        mask_d = mask_q;
        stat_d = stat_q;
        cnt_d = cnt_q + {31'h0000_0000, |ev[`VSX_EV_ECDONE]};
        rdata_d = '0;
        if (reg_wr) begin
            case (reg_addr)
                `VSX_REG_CTRL: ctrl_d = reg_wdata;
                `VSX_REG_EAR: ear_d = reg_wdata[`VSX_RID_W-1:0];
                `VSX_REG_STAT: stat_d = stat_q & ~reg_wdata[`VSX_NEV-1:0];
                `VSX_REG_MASK: mask_d = reg_wdata[`VSX_NEV-1:0];
                default: ctrl_d = ctrl_q;
            endcase
        end
        // Set wins over write-one-to-clear
        stat_d = stat_d | ev;
        if (reg_rd) begin
            case (reg_addr)
                `VSX_REG_CTRL: rdata_d = ctrl_q;
                `VSX_REG_EAR: rdata_d = {{(32-`VSX_RID_W){1'b0}}, ear_q};
                `VSX_REG_STAT: rdata_d = {{(32-`VSX_NEV){1'b0}}, stat_q};
                `VSX_REG_MASK: rdata_d = {{(32-`VSX_NEV){1'b0}}, mask_q};
                `VSX_REG_RDATA: rdata_d = rd_q;
                `VSX_REG_COUNT: rdata_d = cnt_q;
                default: rdata_d = '0;
            endcase
        end
    end

    assign reg_rdata = rdata_q;
    assign irq = |(stat_q & mask_q);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= VSX_IDLE;
            pc_q <= '0;
            addr_q <= '0;
            data_q <= '0;
            wr_q <= 1'b0;
            rd_q <= '0;
            ctrl_q <= `VSX_CTRL_RST;
            ear_q <= '0;
            stat_q <= '0;
            mask_q <= '0;
            cnt_q <= '0;
            rdata_q <= '0;
        end else begin
            st_q <= st_d;
            pc_q <= pc_d;
            addr_q <= addr_d;
            data_q <= data_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            ctrl_q <= ctrl_d;
            ear_q <= ear_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            cnt_q <= cnt_d;
            rdata_q <= rdata_d;
        end
    end
endmodule // vsx_exec

// File: vsx_exec_props.sv
`timescale 1ns/1ns
`include "vsx_cfg.svh"
module vsx_exec_props #(
    parameter int AW = 32,
    parameter int DW = 32
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic issue_valid,
    input wire logic issue_ready,
    input wire logic [31:0] instr,
    input wire logic [AW-1:0] phys_addr,
    input wire logic [DW-1:0] src_data,
    input wire logic segment_direct_store_flag,
    input wire logic page_not_global,
    input wire logic [DW-1:0] time_base_val,
    input wire logic prefetch_flush,
    input wire logic wb_valid,
    input wire logic [DW-1:0] wb_data,
    input wire logic is_spr_read,
    input wire logic cache_valid,
    input wire logic cache_broadcast,
    input wire logic bus_req,
    input wire logic bus_write,
    input wire logic [AW-1:0] bus_addr,
    input wire logic [`VSX_RID_W-1:0] bus_tbst,
    input wire logic [DW-1:0] bus_dout,
    input wire logic bus_doe,
    input wire logic bus_ack
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    wire [9:0] xo = instr[10:1];
    wire ext = instr[31:26] == `VSX_PO_EXT;
    wire tk = issue_valid && issue_ready;
    wire tbop = ext && (xo == `VSX_XO_MFTB || xo == `VSX_XO_MFSPR);
    wire eop = ext && (xo == `VSX_XO_ECIWX || xo == `VSX_XO_ECOWX);
    wire cop = ext && (xo inside {`VSX_XO_DCBF, `VSX_XO_DCBZ, `VSX_XO_DCBST, `VSX_XO_DCBT,
        `VSX_XO_DCBTST, `VSX_XO_ICBI});
    sequence ec_take;
        tk && eop && !segment_direct_store_flag;
    endsequence
    sequence ec_launch;
        bus_req && bus_addr == $past(phys_addr);
    endsequence
    tb_alias_a: assert property (tk && tbop |-> wb_valid && wb_data == time_base_val)
        else $error("time-base read result wrong");
    isync_flush_a: assert property (tk && xo == `VSX_XO_ISYNC |-> prefetch_flush)
        else $error("prefetch not flushed on isync");
    eieio_nop_a: assert property (tk && ext && xo == `VSX_XO_EIEIO |-> !cache_valid ##1 !bus_req)
        else $error("barrier did something");
    ds_nop_a: assert property (tk && cop && segment_direct_store_flag |-> !cache_valid)
        else $error("cache op in direct-store segment");
    no_bcast_a: assert property (tk && cop && page_not_global |-> !cache_broadcast)
        else $error("broadcast on non-global page");
    ec_start_a: assert property (ec_take |=> ec_launch)
        else $error("bus transfer not launched with address");
    req_hold_a: assert property (bus_req && !bus_ack |=> bus_req && $stable(bus_tbst))
        else $error("bus request dropped early");
    ec_ds_a: assert property (tk && eop && segment_direct_store_flag |=> !bus_req [*2])
        else $error("bus used for direct-store segment");
    in_word_a: assert property (bus_req && bus_ack && !bus_write |-> ##[1:8] wb_valid)
        else $error("input word not written back");
    out_data_a: assert property (bus_req && bus_write |-> bus_doe && bus_dout == src_data)
        else $error("output word not driven");
endmodule // vsx_exec_props
bind vsx_exec vsx_exec_props #(.AW(AW), .DW(DW)) i_vsx_exec_props (.sys_clk, .rstn,
    .issue_valid, .issue_ready, .instr, .phys_addr, .src_data, .segment_direct_store_flag,
    .page_not_global, .time_base_val, .prefetch_flush, .wb_valid, .wb_data, .is_spr_read,
    .cache_valid, .cache_broadcast, .bus_req, .bus_write, .bus_addr, .bus_tbst, .bus_dout,
    .bus_doe, .bus_ack);

// File: vsx_pkg.sv
package vsx_pkg;
    typedef enum logic [5:0] {
        VSX_IDLE = 6'b00_0001,
        VSX_DRAIN = 6'b00_0010,
        VSX_REFETCH = 6'b00_0100,
        VSX_BUSREQ = 6'b00_1000,
        VSX_BUSWAIT = 6'b01_0000,
        VSX_DONE = 6'b10_0000
    } vsx_state_t;
    typedef enum logic [3:0] {
        VSX_OP_NONE, VSX_OP_TB, VSX_OP_ISYNC, VSX_OP_EIEIO, VSX_OP_DCBF, VSX_OP_DCBZ,
        VSX_OP_DCBST, VSX_OP_DCBT, VSX_OP_DCBTST, VSX_OP_ICBI, VSX_OP_ECIN, VSX_OP_ECOUT
    } vsx_op_t;
endpackage

// File: vsx_sync2.sv
`timescale 1ns/1ns
module vsx_sync2 #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
        end
    end
    assign dout = s2_q;
endmodule // vsx_sync2
